// file: dv/test_peripheral_pin_route_select.sv
/*
 Self-checking bench for the pin routing block: APB register traffic with a
 fixed-seed random mix, and a full pin and peripheral routing compare.
 Assumes the zero-wait APB slave and the two-edge input sync of pmx_route.
*/
`timescale 1ns/1ps
module test_peripheral_pin_route_select;
	logic clk_sys_i;
	logic reset_i;
	logic psel_i;
	logic penable_i;
	logic pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [3:0] pstrb_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	pmx_pkg::pmx_sig_drv_s periph_drv_i;
	logic [37:0] periph_in_o;
	pmx_pkg::pmx_pin_drv_s gpio_drv_i;
	logic [47:0] pin_i;
	pmx_pkg::pmx_pin_drv_s pin_drv_o;
	logic [47:0] pin_claim_o;
	int mismatches;
	int checked;
	int cyc;
	logic [31:0] rd;
	logic er;
	logic [7:0] sh[16];
	// Writable bits per word index; zero marks an unmapped word
	logic [7:0] msk[16] = '{8'h00, 8'h00, 8'h1F, 8'h03, 8'h00, 8'h07, 8'h03, 8'h3F,
		8'h0F, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int ri[7] = '{2, 3, 5, 6, 7, 8, 10};
	int sbd[4] = '{2, 3, 16, 13};
	int sba[4] = '{44, 45, 12, 17};

	pmx_route dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.periph_drv_i(periph_drv_i), .periph_in_o(periph_in_o), .gpio_drv_i(gpio_drv_i),
		.pin_i(pin_i), .pin_drv_o(pin_drv_o), .pin_claim_o(pin_claim_o));

	initial clk_sys_i = 1'b0;
	always #50 clk_sys_i = ~clk_sys_i;

	task automatic results();
		if (mismatches == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Hang guard, well above the roughly one thousand cycles the sequence needs
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end

	task automatic ck(input logic [95:0] got, input logic [95:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Pin number of signal s under the shadow codes, -1 when unrouted
	function automatic int rt(int s);
		int k;
		int c;
		k = s % 4;
		if (s < 4) begin
			c = sh[2][2:0];
			return c == 0 ? k : c == 1 ? 4 + k : c == 2 ? (k < 2 ? 2 + k : -1) :
				c == 3 ? 28 + k : (c == 4 && k < 3) ? 17 + k : -1;
		end
		if (s < 8) begin
			c = sh[2][4:3];
			return c == 0 ? 16 + k : c == 1 ? 20 + k : (c == 2 && k < 2) ? 30 + k : -1;
		end
		if (s < 12) begin
			c = sh[3][1:0];
			return c == 0 ? 40 + k : (c == 1 && k < 2) ? 44 + k : -1;
		end
		if (s < 16) begin
			c = sh[5][2:0];
			return c == 0 ? 4 + k : c == 1 ? 32 + k : c == 3 ? (k < 2 ? k : 14 + k) :
				c == 4 ? 28 + k : c == 5 ? 16 + k : c == 6 ? (k < 3 ? 17 + k : 47) : -1;
		end
		if (s < 20) begin
			c = sh[6][1:0];
			if (k < 2) return c == 2 ? 18 + k : c == 3 ? k : 2 + k;
			return (c == 1 || c == 2) ? 20 + k : 16 + k;
		end
		if (s < 26) begin
			k = s - 20;
			c = sh[7][2:0];
			return c < 4 ? c * 8 + k : c == 4 ? (k < 4 ? 32 + k : -1) : c == 5 ? 40 + k : -1;
		end
		if (s < 32) begin
			k = s - 26;
			c = sh[7][5:3];
			return c == 0 ? 8 + k : k > 2 ? -1 : c == 1 ? 20 + k : c == 4 ? 4 + k :
				c == 5 ? 28 + k : -1;
		end
		if (s < 36) return sh[8][s - 32] ? sba[s - 32] : sbd[s - 32];
		return sh[10][s - 36] ? 22 : 7;
	endfunction

	task automatic cmp_all();
		pmx_pkg::pmx_pin_drv_s d;
		logic [47:0] cl;
		logic [37:0] pin;
		int p;
		d = gpio_drv_i;
		cl = '0;
		pin = '0;
		// Descending so the lowest-numbered signal owns a shared pin
		for (int s = 37; s >= 0; s--) begin
			p = rt(s);
			if (p >= 0) begin
				cl[p] = 1'b1;
				d.o[p] = periph_drv_i.o[s];
				d.oe[p] = periph_drv_i.oe[s];
				pin[s] = pin_i[p];
			end
		end
		ck(pin_drv_o, d);
		ck(96'(pin_claim_o), 96'(cl));
		ck(96'(periph_in_o), 96'(pin));
	endtask

	// First compare lands just after the write edge, then fresh pin traffic
	task automatic chk();
		#1;
		cmp_all();
		@(posedge clk_sys_i);
		periph_drv_i <= 76'({$urandom, $urandom, $urandom});
		gpio_drv_i <= {$urandom, $urandom, $urandom};
		pin_i <= 48'({$urandom, $urandom});
		repeat (3) @(posedge clk_sys_i);
		#1;
		cmp_all();
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] st, output logic [31:0] rdv, output logic erv);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= st;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		// Wait states end only by ready; the hang guard covers a dead slave
		while (pready_o !== 1'b1) begin
			@(posedge clk_sys_i);
		end
		rdv = prdata_o;
		erv = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input int i, input logic [31:0] d);
		apb(1'b1, 12'(i * 4), d, 4'hF, rd, er);
		sh[i] = d[7:0] & msk[i];
		ck(96'(er), 96'(msk[i] == 8'h00));
	endtask

	task automatic rdc(input int i);
		apb(1'b0, 12'(i * 4), 32'h0, 4'h0, rd, er);
		ck(96'(rd), 96'(sh[i]));
		ck(96'(er), 96'(msk[i] == 8'h00));
	endtask

	initial begin
		mismatches = 0;
		checked = 0;
		cyc = 0;
		foreach (sh[i]) sh[i] = 8'h00;
		reset_i = 1'b1;
		{psel_i, penable_i, pwrite_i} = 3'h0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		pstrb_i = 4'h0;
		periph_drv_i = '0;
		gpio_drv_i = '0;
		pin_i = 48'h0;
		void'($urandom(32'hEA04));
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 16; i++) rdc(i);
		chk();
		// Every code of every field, each write checked on the next cycle
		for (int c = 0; c < 8; c++) begin
			for (int j = 0; j < 7; j++) begin
				wr(ri[j], {24'h0, 2'(c), 3'(c), 3'(c)});
				chk();
			end
		end
		for (int n = 0; n < 60; n++) begin
			wr(ri[$urandom % 7], $urandom);
			chk();
		end
		// Mid-run reset must bring every field back to its default
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		foreach (sh[i]) sh[i] = 8'h00;
		for (int i = 0; i < 16; i++) rdc(i);
		chk();
		wr(4, $urandom);
		wr(9, $urandom);
		apb(1'b1, 12'h014, 32'h0000_0006, 4'hE, rd, er);
		ck(96'(er), 96'h0);
		for (int i = 0; i < 16; i++) rdc(i);
		apb(1'b0, 12'h015, 32'h0, 4'h0, rd, er);
		ck(96'(er), 96'h1);
		ck(96'(rd), 96'h0);
		chk();
		results();
	end
endmodule

// file: src/pmx_pkg.sv
/*
 Shared constants and types for the peripheral pin routing block: register
 indices, field layout, routing codes, port letters and signal numbering.
 Assumes a 32-bit APB slave port with word-aligned registers.
*/
package pmx_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NPIN = 48;
	localparam int NSIG = 38;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_SER01 = 10'h002;
	localparam logic [9:0] IDX_SER2 = 10'h003;
	localparam logic [9:0] IDX_SPI = 10'h005;
	localparam logic [9:0] IDX_I2C = 10'h006;
	localparam logic [9:0] IDX_WAVE = 10'h007;
	localparam logic [9:0] IDX_SINGLE = 10'h008;
	localparam logic [9:0] IDX_CMP = 10'h00A;

	// Field positions inside the shared registers
	localparam int SER0_MSB = 2;
	localparam int SER0_LSB = 0;
	localparam int SER1_MSB = 4;
	localparam int SER1_LSB = 3;
	localparam int WA0_MSB = 2;
	localparam int WA0_LSB = 0;
	localparam int WA1_MSB = 5;
	localparam int WA1_LSB = 3;

	// Routing codes, compared on three bits
	localparam logic [2:0] CODE_DEF = 3'h0;
	localparam logic [2:0] CODE_ALTERNATE_POSITION_ONE = 3'h1;
	localparam logic [2:0] CODE_ALT2 = 3'h2;
	localparam logic [2:0] CODE_ALT3 = 3'h3;
	localparam logic [2:0] CODE_ALT4 = 3'h4;
	localparam logic [2:0] CODE_ALT5 = 3'h5;
	localparam logic [2:0] CODE_ALT6 = 3'h6;

	// Port letters; a pin number is {port, bit}
	localparam logic [2:0] PORT_A = 3'h0;
	localparam logic [2:0] PORT_B = 3'h1;
	localparam logic [2:0] PORT_C = 3'h2;
	localparam logic [2:0] PORT_D = 3'h3;
	localparam logic [2:0] PORT_E = 3'h4;
	localparam logic [2:0] PORT_F = 3'h5;

	// First signal of each peripheral in the flat signal vector
	localparam int SIG_SER0 = 0;
	localparam int SIG_SER1 = 4;
	localparam int SIG_SER2 = 8;
	localparam int SIG_SPI = 12;
	localparam int SIG_I2C = 16;
	localparam int SIG_WA0 = 20;
	localparam int SIG_WA1 = 26;
	localparam int SIG_SB = 32;
	localparam int SIG_CMP = 36;

	typedef struct packed {
		logic [4:0] ser01;
		logic [1:0] ser2;
		logic [2:0] spi;
		logic [1:0] i2c;
		logic [5:0] wave;
		logic [3:0] single;
		logic [1:0] cmp;
	} pmx_regs_s;

	localparam pmx_regs_s REGS_RST = '0;

	typedef struct packed {
		logic en;
		logic [5:0] pin;
	} pmx_route_s;

	typedef struct packed {
		logic [NSIG-1:0] o;
		logic [NSIG-1:0] oe;
	} pmx_sig_drv_s;

	typedef struct packed {
		logic [NPIN-1:0] o;
		logic [NPIN-1:0] oe;
	} pmx_pin_drv_s;

	typedef struct packed {
		pmx_regs_s regs;
		logic [DATA_W-1:0] prdata;
	} pmx_state_s;

	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
	} pmx_sync_s;

	function automatic pmx_route_s pmx_mk(input logic [2:0] port, input int n);
		return {1'b1, port, 3'(n)};
	endfunction

endpackage

// file: src/pmx_route.sv
/*
 Peripheral pin routing block: APB register file holding the routing codes,
 the code-to-pin decode, the per-pin output multiplexers and the per-signal input multiplexers.
 Assumes peripherals and the port output logic run on clk_sys_i and the
 pads are asynchronous.
*/
// Local design decision: register access over APB.
`timescale 1ns/1ps
module pmx_route (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [pmx_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [pmx_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [pmx_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire pmx_pkg::pmx_sig_drv_s periph_drv_i,
	output logic [pmx_pkg::NSIG-1:0] periph_in_o,
	input wire pmx_pkg::pmx_pin_drv_s gpio_drv_i,
	input wire logic [pmx_pkg::NPIN-1:0] pin_i,
	output pmx_pkg::pmx_pin_drv_s pin_drv_o,
	output logic [pmx_pkg::NPIN-1:0] pin_claim_o
);

	localparam int NSIG = pmx_pkg::NSIG;
	localparam int NPIN = pmx_pkg::NPIN;
	localparam logic [2:0] PA = pmx_pkg::PORT_A;
	localparam logic [2:0] PB = pmx_pkg::PORT_B;
	localparam logic [2:0] PC = pmx_pkg::PORT_C;
	localparam logic [2:0] PD = pmx_pkg::PORT_D;
	localparam logic [2:0] PE = pmx_pkg::PORT_E;
	localparam logic [2:0] PF = pmx_pkg::PORT_F;
	localparam int S0 = pmx_pkg::SIG_SER0;
	localparam int S1 = pmx_pkg::SIG_SER1;
	localparam int S2 = pmx_pkg::SIG_SER2;
	localparam int SP = pmx_pkg::SIG_SPI;
	localparam int TW = pmx_pkg::SIG_I2C;
	localparam int W0 = pmx_pkg::SIG_WA0;
	localparam int W1 = pmx_pkg::SIG_WA1;
	localparam int SB = pmx_pkg::SIG_SB;
	localparam int CM = pmx_pkg::SIG_CMP;

	pmx_pkg::pmx_state_s st_ff;
	pmx_pkg::pmx_state_s nxt_st;
	pmx_pkg::pmx_regs_s r;
	pmx_pkg::pmx_route_s [NSIG-1:0] rt;
	logic [NPIN-1:0] sync_q;
	logic [NPIN-1:0] pin_o;
	logic [NPIN-1:0] pin_oe;
	logic [9:0] idx;
	logic setup;
	logic acc;
	logic hit;
	logic wr;
	logic [7:0] rd_val;
	logic [2:0] c_s0;
	logic [2:0] c_s1;
	logic [2:0] c_s2;
	logic [2:0] c_spi;
	logic [2:0] c_tw;
	logic [2:0] c_w0;
	logic [2:0] c_w1;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);

	assign r = st_ff.regs;
	assign c_s0 = r.ser01[pmx_pkg::SER0_MSB:pmx_pkg::SER0_LSB];
	assign c_s1 = 3'(r.ser01[pmx_pkg::SER1_MSB:pmx_pkg::SER1_LSB]);
	assign c_s2 = 3'(r.ser2);
	assign c_spi = r.spi;
	assign c_tw = 3'(r.i2c);
	assign c_w0 = r.wave[pmx_pkg::WA0_MSB:pmx_pkg::WA0_LSB];
	assign c_w1 = r.wave[pmx_pkg::WA1_MSB:pmx_pkg::WA1_LSB];

	pmx_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.pin_i(pin_i),
		.pin_q_o(sync_q)
	);

	// APB decode; word aligned accesses only
	assign idx = paddr_i[pmx_pkg::ADDR_W-1:2];
	assign setup = psel_i & ~penable_i;
	assign acc = psel_i & penable_i;

	always_comb begin
		hit = (paddr_i[1:0] == 2'h0);
		case (idx)
			pmx_pkg::IDX_SER01: rd_val = 8'(r.ser01);
			pmx_pkg::IDX_SER2: rd_val = 8'(r.ser2);
			pmx_pkg::IDX_SPI: rd_val = 8'(r.spi);
			pmx_pkg::IDX_I2C: rd_val = 8'(r.i2c);
			pmx_pkg::IDX_WAVE: rd_val = 8'(r.wave);
			pmx_pkg::IDX_SINGLE: rd_val = 8'(r.single);
			pmx_pkg::IDX_CMP: rd_val = 8'(r.cmp);
			default: begin
				rd_val = 8'h00;
				hit = 1'b0;
			end
		endcase
	end

	// Always ready: reads are staged in the setup cycle so prdata is a flop
	assign pready_o = 1'b1;
	assign pslverr_o = acc & ~hit;
	assign prdata_o = st_ff.prdata;
	assign wr = acc & pwrite_i & hit & pstrb_i[0];

	always_comb begin
		nxt_st = st_ff;
		if (setup & ~pwrite_i) begin
			nxt_st.prdata = 32'(rd_val);
		end
		if (wr) begin
			case (idx)
				pmx_pkg::IDX_SER01: nxt_st.regs.ser01 = pwdata_i[4:0];
				pmx_pkg::IDX_SER2: nxt_st.regs.ser2 = pwdata_i[1:0];
				pmx_pkg::IDX_SPI: nxt_st.regs.spi = pwdata_i[2:0];
				pmx_pkg::IDX_I2C: nxt_st.regs.i2c = pwdata_i[1:0];
				pmx_pkg::IDX_WAVE: nxt_st.regs.wave = pwdata_i[5:0];
				pmx_pkg::IDX_SINGLE: nxt_st.regs.single = pwdata_i[3:0];
				pmx_pkg::IDX_CMP: nxt_st.regs.cmp = pwdata_i[1:0];
				default: nxt_st.regs = st_ff.regs;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			st_ff.regs <= pmx_pkg::REGS_RST;
			st_ff.prdata <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Code to pin decode; reserved and none codes leave the signal unrouted
	always_comb begin
		rt = '0;
		for (int k = 0; k < 4; k++) begin
			case (c_s0)
				pmx_pkg::CODE_DEF: rt[S0+k] = pmx_pkg::pmx_mk(PA, k);
				pmx_pkg::CODE_ALTERNATE_POSITION_ONE: rt[S0+k] = pmx_pkg::pmx_mk(PA, 4+k);
				pmx_pkg::CODE_ALT2: if (k < 2) rt[S0+k] = pmx_pkg::pmx_mk(PA, 2+k);
				pmx_pkg::CODE_ALT3: rt[S0+k] = pmx_pkg::pmx_mk(PD, 4+k);
				pmx_pkg::CODE_ALT4: if (k < 3) rt[S0+k] = pmx_pkg::pmx_mk(PC, 1+k);
				default: rt[S0+k] = '0;
			endcase
			case (c_s1)
				pmx_pkg::CODE_DEF: rt[S1+k] = pmx_pkg::pmx_mk(PC, k);
				pmx_pkg::CODE_ALTERNATE_POSITION_ONE: rt[S1+k] = pmx_pkg::pmx_mk(PC, 4+k);
				pmx_pkg::CODE_ALT2: if (k < 2) rt[S1+k] = pmx_pkg::pmx_mk(PD, 6+k);
				default: rt[S1+k] = '0;
			endcase
			case (c_s2)
				pmx_pkg::CODE_DEF: rt[S2+k] = pmx_pkg::pmx_mk(PF, k);
				pmx_pkg::CODE_ALTERNATE_POSITION_ONE: if (k < 2) rt[S2+k] = pmx_pkg::pmx_mk(PF, 4+k);
				default: rt[S2+k] = '0;
			endcase
			case (c_spi)
				pmx_pkg::CODE_DEF: rt[SP+k] = pmx_pkg::pmx_mk(PA, 4+k);
				pmx_pkg::CODE_ALTERNATE_POSITION_ONE: rt[SP+k] = pmx_pkg::pmx_mk(PE, k);
				pmx_pkg::CODE_ALT3: rt[SP+k] = pmx_pkg::pmx_mk(k < 2 ? PA : PC, k%2);
				pmx_pkg::CODE_ALT4: rt[SP+k] = pmx_pkg::pmx_mk(PD, 4+k);
				pmx_pkg::CODE_ALT5: rt[SP+k] = pmx_pkg::pmx_mk(PC, k);
				pmx_pkg::CODE_ALT6: rt[SP+k] = pmx_pkg::pmx_mk(k < 3 ? PC : PF, k < 3 ? 1+k : 7);
				default: rt[SP+k] = '0;
			endcase
		end
		// I2C: two host/client lines, then the dual mode client pair
		for (int k = 0; k < 2; k++) begin
			case (c_tw)
				pmx_pkg::CODE_ALT2: rt[TW+k] = pmx_pkg::pmx_mk(PC, 2+k);
				pmx_pkg::CODE_ALT3: rt[TW+k] = pmx_pkg::pmx_mk(PA, k);
				default: rt[TW+k] = pmx_pkg::pmx_mk(PA, 2+k);
			endcase
			case (c_tw)
				pmx_pkg::CODE_ALTERNATE_POSITION_ONE, pmx_pkg::CODE_ALT2: rt[TW+2+k] = pmx_pkg::pmx_mk(PC, 6+k);
				default: rt[TW+2+k] = pmx_pkg::pmx_mk(PC, 2+k);
			endcase
		end
		for (int k = 0; k < 6; k++) begin
			// Wave timer A0 codes coincide with the port letters
			if (c_w0 <= PF && (c_w0 != PE || k < 4)) begin
				rt[W0+k] = pmx_pkg::pmx_mk(c_w0, k);
			end
			case (c_w1)
				pmx_pkg::CODE_DEF: rt[W1+k] = pmx_pkg::pmx_mk(PB, k);
				pmx_pkg::CODE_ALTERNATE_POSITION_ONE: if (k < 3) rt[W1+k] = pmx_pkg::pmx_mk(PC, 4+k);
				pmx_pkg::CODE_ALT4: if (k < 3) rt[W1+k] = pmx_pkg::pmx_mk(PA, 4+k);
				pmx_pkg::CODE_ALT5: if (k < 3) rt[W1+k] = pmx_pkg::pmx_mk(PD, 4+k);
				default: rt[W1+k] = '0;
			endcase
		end
		rt[SB+0] = r.single[0] ? pmx_pkg::pmx_mk(PF, 4) : pmx_pkg::pmx_mk(PA, 2);
		rt[SB+1] = r.single[1] ? pmx_pkg::pmx_mk(PF, 5) : pmx_pkg::pmx_mk(PA, 3);
		rt[SB+2] = r.single[2] ? pmx_pkg::pmx_mk(PB, 4) : pmx_pkg::pmx_mk(PC, 0);
		rt[SB+3] = r.single[3] ? pmx_pkg::pmx_mk(PC, 1) : pmx_pkg::pmx_mk(PB, 5);
		rt[CM+0] = r.cmp[0] ? pmx_pkg::pmx_mk(PC, 6) : pmx_pkg::pmx_mk(PA, 7);
		rt[CM+1] = r.cmp[1] ? pmx_pkg::pmx_mk(PC, 6) : pmx_pkg::pmx_mk(PA, 7);
	end

	// Per pin output mux. Where two routed signals share a pin the lower
	// numbered signal drives it; software must avoid such overlaps.
	for (genvar p = 0; p < NPIN; p++) begin : g_pin
		logic own;
		logic po;
		logic poe;
		always_comb begin
			own = 1'b0;
			po = 1'b0;
			poe = 1'b0;
			for (int s = NSIG-1; s >= 0; s--) begin
				if (rt[s].en && rt[s].pin == 6'(p)) begin
					own = 1'b1;
					po = periph_drv_i.o[s];
					poe = periph_drv_i.oe[s];
				end
			end
		end
		assign pin_claim_o[p] = own;
		assign pin_o[p] = own ? po : gpio_drv_i.o[p];
		assign pin_oe[p] = own ? poe : gpio_drv_i.oe[p];
		a_pin_released: assert property (!own |-> pin_drv_o.o[p] == gpio_drv_i.o[p]
			&& pin_drv_o.oe[p] == gpio_drv_i.oe[p])
			else $error("unclaimed pin not released to port logic");
	end

	assign pin_drv_o = '{o: pin_o, oe: pin_oe};

	// Peripheral inputs read the synchronised level of their routed pin
	for (genvar s = 0; s < NSIG; s++) begin : g_sig
		assign periph_in_o[s] = rt[s].en & sync_q[rt[s].pin];
	end

	// Routing checks look at the decoded table and at the pins it claims; register checks at writes, reset and readback
	a_ser1_alternate_position_one: assert property (c_s1 == 3'h1 |-> pin_claim_o[{PC, 3'h6}]
		&& periph_in_o[S1+1] == sync_q[{PC, 3'h5}])
		else $error("serial one alternate pins wrong");
	a_ser0_alt4: assert property (c_s0 == 3'h4 |-> rt[S0+2].pin == {PC, 3'h3}
		&& !rt[S0+3].en)
		else $error("serial zero code four pins wrong");
	a_ser2_resv: assert property (c_s2 == 3'h2 |->
		!(rt[S2].en | rt[S2+1].en | rt[S2+2].en | rt[S2+3].en))
		else $error("serial two reserved code routed a pin");
	a_spi_alt3: assert property (c_spi == 3'h3 |-> rt[SP+2].pin == {PC, 3'h0})
		else $error("spi code three clock pin wrong");
	a_spi_alt6: assert property (c_spi == 3'h6 |-> pin_claim_o[{PF, 3'h7}]
		&& pin_drv_o.o[{PF, 3'h7}] == periph_drv_i.o[SP+3])
		else $error("spi code six select not on F7");
	a_i2c_dual: assert property (c_tw == 3'h2 |-> rt[TW].pin == {PC, 3'h2}
		&& rt[TW+3].pin == {PC, 3'h7})
		else $error("i2c code two pins wrong");
	a_wave_a1: assert property (c_w1 == 3'h5 |-> rt[W1+2].pin == {PD, 3'h6}
		&& !rt[W1+3].en)
		else $error("wave timer a1 port d pins wrong");
	a_wave_a0: assert property (c_w0 == 3'h4 |-> !rt[W0+4].en
		&& rt[W0+3].pin == {PE, 3'h3})
		else $error("wave timer a0 port e pins wrong");
	a_single_b3: assert property (r.single[3] |-> pin_claim_o[{PC, 3'h1}])
		else $error("single timer b3 not on C1");
	a_single_b2: assert property (!r.single[2] |-> rt[SB+2].pin == {PC, 3'h0})
		else $error("single timer b2 not on C0");
	a_single_b1: assert property (r.single[1] |-> rt[SB+1].pin == {PF, 3'h5})
		else $error("single timer b1 not on F5");
	a_single_b0: assert property (!r.single[0] |-> rt[SB].pin == {PA, 3'h2})
		else $error("single timer b0 not on A2");
	a_cmp_one: assert property (r.cmp[1] |-> rt[CM+1].pin == {PC, 3'h6})
		else $error("comparator one not on C6");
	a_cmp_zero: assert property (!r.cmp[0] |-> rt[CM].pin == {PA, 3'h7})
		else $error("comparator zero not on A7");
	a_write_takes: assert property (wr && idx == pmx_pkg::IDX_SPI |=>
		c_spi == $past(pwdata_i[2:0]))
		else $error("spi routing write did not take effect");
	a_reset_zero: assert property ($past(reset_i) |-> r == pmx_pkg::REGS_RST)
		else $error("routing fields not zero after reset");
	a_ser1_none: assert property (c_s1 == 3'h3 |->
		!(rt[S1].en | rt[S1+1].en | rt[S1+2].en | rt[S1+3].en))
		else $error("serial one none code routed a pin");
	a_ser1_alt2: assert property (c_s1 == 3'h2 |-> rt[S1].pin == {PD, 3'h6}
		&& !rt[S1+2].en)
		else $error("serial one code two pins wrong");
	a_ser0_none: assert property (c_s0 == 3'h5 |->
		!(rt[S0].en | rt[S0+1].en | rt[S0+2].en | rt[S0+3].en))
		else $error("serial zero none code routed a pin");
	a_ser0_alt2: assert property (c_s0 == 3'h2 |-> rt[S0+1].pin == {PA, 3'h3}
		&& !rt[S0+2].en)
		else $error("serial zero code two pins wrong");
	a_ser2_alternate_position_one: assert property (c_s2 == 3'h1 |-> rt[S2+1].pin == {PF, 3'h5}
		&& !rt[S2+3].en)
		else $error("serial two code one pins wrong");
	a_spi_resv: assert property (c_spi == 3'h2 |->
		!(rt[SP].en | rt[SP+1].en | rt[SP+2].en | rt[SP+3].en))
		else $error("spi reserved code routed a pin");
	a_spi_none: assert property (c_spi == 3'h7 |->
		!(rt[SP].en | rt[SP+1].en | rt[SP+2].en | rt[SP+3].en))
		else $error("spi none code routed a pin");
	a_i2c_alt3: assert property (c_tw == 3'h3 |-> rt[TW].pin == {PA, 3'h0}
		&& rt[TW+2].pin == {PC, 3'h2})
		else $error("i2c code three pins wrong");
	a_wave_a1_resv: assert property (c_w1 == 3'h2 |->
		!(rt[W1].en | rt[W1+1].en | rt[W1+2].en))
		else $error("wave timer a1 reserved code routed a pin");
	a_wave_a0_resv: assert property (c_w0 == 3'h7 |->
		!(rt[W0].en | rt[W0+5].en))
		else $error("wave timer a0 reserved code routed a pin");
	a_single_write: assert property (wr && idx == pmx_pkg::IDX_SINGLE |=>
		r.single == $past(pwdata_i[3:0]))
		else $error("single timer routing write did not take effect");
	a_unrouted_in: assert property (!rt[SP+1].en |->
		!periph_in_o[SP+1])
		else $error("unrouted peripheral input not held low");
	a_read_stage: assert property (setup && !pwrite_i && idx == pmx_pkg::IDX_SPI |=>
		prdata_o == 32'($past(c_spi)))
		else $error("spi routing readback wrong");

	c_spi_alt6: cover property (c_spi == 3'h6 && periph_drv_i.oe[SP+3]);
	c_slverr: cover property (pslverr_o);
	c_overlap: cover property (c_s0 == 3'h1 && c_spi == 3'h0);
	c_single_alt: cover property (r.single == 4'hF);
	c_wave_e: cover property (c_w0 == 3'h4);

endmodule

// file: src/pmx_sync.sv
/*
 Two-stage synchroniser for the raw pad input levels.
 Assumes the pads are asynchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module pmx_sync (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [pmx_pkg::NPIN-1:0] pin_i,
	output logic [pmx_pkg::NPIN-1:0] pin_q_o
);

	pmx_pkg::pmx_sync_s st_ff;
	pmx_pkg::pmx_sync_s nxt_st;

	// First stage feeds only the second stage
	always_comb begin
		nxt_st.s1 = pin_i;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pin_q_o = st_ff.s2;

endmodule
